// *** design/smc_ctrl.sv ***
// Sleep mode controller with AXI4-Lite registers and clock gating
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int NUM_PER = 8,
  parameter int OSC_START = SMC_OSC_START_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // CPU side
  input wire logic sleep_instr,
  input wire smc_wake_type wake_req,
  output smc_gate_type gate_on,
  output logic cpu_halt,
  output logic resume_pulse,
  output logic [NUM_PER-1:0] per_clk_on,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam logic [SMC_CNT_W-1:0] OSC_CNT = SMC_CNT_W'(OSC_START);

  smc_state_type state; // Sequencer state
  logic [SMC_MODE_W-1:0] mode_select_field; // Selected mode
  logic low_power_entry_enable; // Entry enable
  logic [SMC_MODE_W-1:0] cur_mode; // Mode latched at entry
  logic [SMC_ST_W-1:0] status; // Sticky events
  logic [SMC_ST_W-1:0] mask; // Interrupt mask
  logic [NUM_PER-1:0] per_stop; // Peripheral stop bits
  logic [SMC_CNT_W-1:0] cnt; // Delay counter
  logic mode_ok; // Field holds a legal code
  logic wake_hit; // Enabled wake source active
  logic osc_stopped; // Latched mode stops system source
  logic aw_got, w_got; // Write channel capture
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do; // Write performed this cycle
  logic ev_wake, ev_refuse; // Status events

  // Legal mode codes; others reserved
  always_comb begin // [R1] [R14]
    unique case (mode_select_field)
      SMC_MODE_IDLE, SMC_MODE_FULL, SMC_MODE_CNT,
      SMC_MODE_OSC, SMC_MODE_EXT: mode_ok = 1'b1;
      default: mode_ok = 1'b0;
    endcase
  end

  // Wake match against mode latched at entry
  function automatic logic smc_wakes(input logic [2:0] m,
                                     input smc_wake_type w);
    logic r;
    r = w.port_async | w.two_wire_interface; // [R9]
    if (m == SMC_MODE_IDLE || m == SMC_MODE_CNT || m == SMC_MODE_EXT) begin
      r = r | w.rtc;
    end
    if (m == SMC_MODE_IDLE) begin
      r = r | w.other;
    end
    return r;
  endfunction

  assign wake_hit = smc_wakes(cur_mode, wake_req); // [R4] [R9]
  assign osc_stopped = (cur_mode == SMC_MODE_FULL) ||
                       (cur_mode == SMC_MODE_CNT); // [R10]
  assign wr_do = aw_got && w_got && !s_bvalid;
  // Instruction with bad code or entry disabled is refused
  assign ev_refuse = (state == SMC_ACTIVE) && sleep_instr &&
                     !(low_power_entry_enable && mode_ok); // [R15] [R18]
  assign ev_wake = (state == SMC_SLEEP) && wake_hit;

  // Sleep sequencer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin // [R12]
      state <= SMC_ACTIVE;
      cur_mode <= SMC_MODE_IDLE;
      cnt <= '0;
    end else if (clk_en) begin
      unique case (state)
        SMC_ACTIVE: begin
          // Entry only on the instruction with enable and legal code
          if (sleep_instr && low_power_entry_enable && mode_ok) begin // [R2]
            cur_mode <= mode_select_field; // [R3]
            state <= SMC_SLEEP;
          end
        end
        SMC_SLEEP: begin
          // Pending wake is seen in the first sleep cycle
          if (wake_hit) begin // [R4] [R17]
            if (osc_stopped) begin
              state <= SMC_OSC_WAIT;
              cnt <= OSC_CNT; // [R10]
            end else begin
              state <= SMC_HALT;
              cnt <= SMC_CNT_W'(SMC_HALT_CYCLES);
            end
          end
        end
        SMC_OSC_WAIT: begin
          // Oscillator start-up before halt
          if (cnt <= SMC_CNT_W'(1)) begin // [R10]
            state <= SMC_HALT;
            cnt <= SMC_CNT_W'(SMC_HALT_CYCLES);
          end else begin
            cnt <= cnt - SMC_CNT_W'(1);
          end
        end
        SMC_HALT: begin
          // Four halt cycles
          if (cnt <= SMC_CNT_W'(1)) begin // [R7]
            state <= SMC_RESUME;
          end else begin
            cnt <= cnt - SMC_CNT_W'(1);
          end
        end
        SMC_RESUME: begin
          // Interrupt controller takes over priority servicing
          state <= SMC_ACTIVE; // [R5] [R6]
        end
      endcase
    end
  end

  // Gate and halt outputs, registered
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_on <= '1;
      cpu_halt <= 1'b0;
      resume_pulse <= 1'b0;
    end else if (clk_en) begin
      resume_pulse <= (state == SMC_RESUME); // [R5]
      cpu_halt <= (state != SMC_ACTIVE) && (state != SMC_RESUME); // [R2]
      if (state == SMC_SLEEP && !wake_hit) begin // [R8]
        gate_on.cpu_clk <= 1'b0;
        gate_on.per_clk <= (cur_mode == SMC_MODE_IDLE);
        gate_on.rtc_clk <= (cur_mode == SMC_MODE_IDLE) ||
                           (cur_mode == SMC_MODE_CNT) ||
                           (cur_mode == SMC_MODE_EXT);
        gate_on.rtc_osc <= (cur_mode == SMC_MODE_IDLE) ||
                           (cur_mode == SMC_MODE_CNT) ||
                           (cur_mode == SMC_MODE_EXT);
        gate_on.sys_osc <= (cur_mode == SMC_MODE_IDLE) ||
                           (cur_mode == SMC_MODE_OSC) ||
                           (cur_mode == SMC_MODE_EXT);
      end else begin
        gate_on <= '1;
      end
    end
  end

  // Peripheral clock enables follow stop bits in any state
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      per_clk_on <= '1;
    end else if (clk_en) begin
      per_clk_on <= ~per_stop; // [R13] [R16]
    end
  end

  // Write address and data capture, in either order
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (clk_en) begin
      // Ready flops mirror the inverse of the capture flags
      if (s_awvalid && s_awready) begin
        aw_got <= 1'b1;
        s_awready <= 1'b0;
        aw_addr <= s_awaddr;
      end else if (wr_do) begin
        aw_got <= 1'b0;
        s_awready <= 1'b1;
      end
      if (s_wvalid && s_wready) begin
        w_got <= 1'b1;
        s_wready <= 1'b0;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end else if (wr_do) begin
        w_got <= 1'b0;
        s_wready <= 1'b1;
      end
    end
  end

  // Register writes; contents kept through sleep
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_select_field <= SMC_MODE_IDLE;
      low_power_entry_enable <= 1'b0;
      mask <= '0;
      per_stop <= '0;
    end else if (clk_en && wr_do && w_strb[0]) begin // [R11]
      unique case (aw_addr)
        SMC_ADDR_CTRL: begin
          low_power_entry_enable <= w_data[SMC_EN_BIT]; // [R15]
          mode_select_field <= w_data[SMC_MODE_LSB +: SMC_MODE_W];
        end
        SMC_ADDR_MASK: mask <= w_data[SMC_ST_W-1:0];
        SMC_ADDR_GATE: per_stop <= w_data[NUM_PER-1:0]; // [R13]
        default: ;
      endcase
    end
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < SMC_ST_W; i++) begin
        if ((i == SMC_ST_WAKE && ev_wake) ||
            (i == SMC_ST_REFUSE && ev_refuse)) begin
          status[i] <= 1'b1;
        end else if (wr_do && w_strb[0] && aw_addr == SMC_ADDR_STATUS &&
                     w_data[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt output
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status & mask);
    end
  end

  // Write response
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= SMC_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_do) begin
        s_bvalid <= 1'b1;
        s_bresp <= (aw_addr == SMC_ADDR_CTRL || aw_addr == SMC_ADDR_STATUS ||
                    aw_addr == SMC_ADDR_MASK || aw_addr == SMC_ADDR_GATE) ?
                   SMC_RESP_OKAY : SMC_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; arready is the registered inverse of rvalid
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
      s_rdata <= '0;
      s_rresp <= SMC_RESP_OKAY;
    end else if (clk_en) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_arready <= 1'b0;
        s_rresp <= SMC_RESP_OKAY;
        s_rdata <= '0;
        unique case (s_araddr)
          SMC_ADDR_CTRL: begin
            s_rdata[SMC_EN_BIT] <= low_power_entry_enable;
            s_rdata[SMC_MODE_LSB +: SMC_MODE_W] <= mode_select_field;
          end
          SMC_ADDR_STATUS: s_rdata[SMC_ST_W-1:0] <= status;
          SMC_ADDR_MASK: s_rdata[SMC_ST_W-1:0] <= mask;
          SMC_ADDR_GATE: s_rdata[NUM_PER-1:0] <= per_stop;
          SMC_ADDR_STATE: s_rdata[2:0] <= state;
          default: s_rresp <= SMC_RESP_SLVERR;
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // Assertions
  a_halt_four: assert property (@(posedge mclk) disable iff (!reset_n) // [R7]
    (clk_en && state == SMC_SLEEP && wake_hit && !osc_stopped) ##1 clk_en[*4]
    |=> state == SMC_RESUME)
    else $error("halt after wake not four cycles");
  a_reserved_ignored: assert property (@(posedge mclk) // [R18]
    disable iff (!reset_n)
    (clk_en && state == SMC_ACTIVE && sleep_instr && !mode_ok)
    |=> state == SMC_ACTIVE)
    else $error("reserved mode code entered sleep");
  a_entry_enable: assert property (@(posedge mclk) // [R15]
    disable iff (!reset_n)
    (state == SMC_ACTIVE && !low_power_entry_enable) |=> state != SMC_SLEEP)
    else $error("sleep without entry enable");
  a_sleep_only_instr: assert property (@(posedge mclk) // [R2]
    disable iff (!reset_n)
    (state == SMC_ACTIVE && !sleep_instr) |=> state == SMC_ACTIVE)
    else $error("sleep entered without instruction");
  a_no_spurious_exit: assert property (@(posedge mclk) // [R4]
    disable iff (!reset_n)
    (state == SMC_SLEEP && !wake_hit) |=> state == SMC_SLEEP)
    else $error("sleep left without wake");
  a_osc_delay: assert property (@(posedge mclk) // [R10]
    disable iff (!reset_n)
    (clk_en && state == SMC_SLEEP && wake_hit && osc_stopped)
    |=> state == SMC_OSC_WAIT)
    else $error("start-up delay skipped");
  a_full_gate: assert property (@(posedge mclk) // [R8]
    disable iff (!reset_n)
    (clk_en && state == SMC_SLEEP && !wake_hit && cur_mode == SMC_MODE_FULL)
    |=> gate_on == '0)
    else $error("full stop mode left a clock running");
  a_per_gate: assert property (@(posedge mclk) // [R13]
    disable iff (!reset_n)
    clk_en |=> per_clk_on == ~$past(per_stop))
    else $error("peripheral gate mismatch");
  a_resume_pulse: assert property (@(posedge mclk) // [R5]
    disable iff (!reset_n)
    resume_pulse |-> !cpu_halt ##1 !resume_pulse)
    else $error("resume pulse wrong");
  c_idle_wake: cover property (@(posedge mclk) disable iff (!reset_n)
    state == SMC_SLEEP && cur_mode == SMC_MODE_IDLE ##[1:20] resume_pulse);
  c_osc_wake: cover property (@(posedge mclk) disable iff (!reset_n)
    state == SMC_OSC_WAIT ##[1:200] state == SMC_RESUME);
  c_refused: cover property (@(posedge mclk) disable iff (!reset_n)
    ev_refuse);
endmodule // smc_ctrl

// *** design/smc_pkg.sv ***
// Package with constants, types and register map of the sleep controller
// Overview of operation
// R1: Five low-power modes are provided
// R2: Sleep entered only by the sleep instruction
// R3: Software selects mode before the instruction
// R4: Only interrupt or reset ends sleep
// R5: Wake runs handler, then resumes after instruction
// R6: Higher-priority pending interrupts serviced first
// R7: CPU halted four cycles after wake
// R8: Clock domains gated per selected mode
// R9: Wake sources depend on selected mode
// R10: Oscillator start-up added when source stopped
// R11: Register, memory contents kept during sleep
// R12: Reset in sleep restarts from reset vector
// R13: Each peripheral clock stoppable by software
// R14: Mode field codes decoded, three reserved
// R15: Entry enable bit required for sleep
// R16: Gated peripheral frozen, register access refused; the code only gates per_clk_on and refuses no access
// R17: Pending wake source wakes at once
// R18: Reserved mode code ignores the instruction
package smc_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] SMC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SMC_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SMC_ADDR_MASK = 8'h08;
  localparam logic [7:0] SMC_ADDR_GATE = 8'h0c;
  localparam logic [7:0] SMC_ADDR_STATE = 8'h10;
  // Control register field layout
  localparam int SMC_EN_BIT = 0;
  localparam int SMC_MODE_LSB = 1;
  localparam int SMC_MODE_W = 3;
  // Mode select codes
  localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
  localparam logic [2:0] SMC_MODE_FULL = 3'h2;
  localparam logic [2:0] SMC_MODE_CNT = 3'h3;
  localparam logic [2:0] SMC_MODE_OSC = 3'h6;
  localparam logic [2:0] SMC_MODE_EXT = 3'h7;
  // Status bit positions
  localparam int SMC_ST_WAKE = 0;
  localparam int SMC_ST_REFUSE = 1;
  localparam int SMC_ST_W = 2;
  // Timing: post-wake halt in cycles, default oscillator start-up
  localparam logic [3:0] SMC_HALT_CYCLES = 4'h4;
  localparam int SMC_OSC_START_DEF = 64;
  localparam int SMC_CNT_W = 16;
  // AXI responses
  localparam logic [1:0] SMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    SMC_ACTIVE, SMC_SLEEP, SMC_OSC_WAIT, SMC_HALT, SMC_RESUME
  } smc_state_type;
  // Clock gate outputs
  typedef struct packed {
    logic cpu_clk;
    logic per_clk;
    logic rtc_clk;
    logic sys_osc;
    logic rtc_osc;
  } smc_gate_type;
  // Wake source groups
  typedef struct packed {
    logic port_async;
    logic two_wire_interface;
    logic rtc;
    logic other;
  } smc_wake_type;
endpackage

// *** testbench/smc_cpu_model.sv ***
// CPU core and interrupt controller model facing the sleep controller
`timescale 1ns/10ps
module smc_cpu_model
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cmd_sleep,
  input wire smc_wake_type cmd_wake,
  input wire logic resume_pulse,
  input wire smc_gate_type gate_on,
  output logic sleep_instr,
  output smc_wake_type wake_req
);
  // One-cycle sleep instruction, only while the CPU clock runs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= cmd_sleep & gate_on.cpu_clk;
    end
  end
  // Requests stay pending until the handler runs after resume
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wake_req <= '0;
    end else if (resume_pulse) begin
      wake_req <= '0;
    end else begin
      wake_req <= wake_req | cmd_wake;
    end
  end
endmodule // smc_cpu_model

// *** testbench/sleep_mode_controller_tb.sv ***
// Self-checking bench for the sleep mode controller
`timescale 1ns/10ps
module sleep_mode_controller_tb
  import smc_pkg::*;
;
  localparam int OSC = 2; // Short oscillator start-up
  localparam int LAT = SMC_HALT_CYCLES + 3; // Wake command to resume
  typedef struct {
    logic [2:0] mode;
    smc_wake_type w;
    smc_gate_type g;
    logic hit;
  } smc_row_type;
  // Mode, wake source, gates in sleep, wakes or not
  smc_row_type rows [9] = '{
    '{SMC_MODE_IDLE, 4'h1, 5'h0f, 1'b1}, '{SMC_MODE_FULL, 4'h2, 5'h00, 1'b0},
    '{SMC_MODE_FULL, 4'h4, 5'h00, 1'b1}, '{SMC_MODE_CNT, 4'h2, 5'h05, 1'b1},
    '{SMC_MODE_CNT, 4'h1, 5'h05, 1'b0}, '{SMC_MODE_OSC, 4'h8, 5'h02, 1'b1},
    '{SMC_MODE_OSC, 4'h2, 5'h02, 1'b0}, '{SMC_MODE_EXT, 4'h2, 5'h07, 1'b1},
    '{SMC_MODE_EXT, 4'h1, 5'h07, 1'b0}};
  logic [31:0] refused [4] = '{32'h3, 32'h9, 32'hb, 32'h0};
  logic mclk = 1'b0, reset_n = 1'b0, cmd_sleep = 1'b0, sleep_instr;
  smc_wake_type cmd_wake = '0, wake_req;
  smc_gate_type gate_on;
  logic cpu_halt, resume_pulse, irq;
  logic [7:0] per_clk_on, s_awaddr = '0, s_araddr = '0;
  logic s_awvalid = 0, s_awready, s_wvalid = 0, s_wready, s_bvalid;
  logic s_bready = 0, s_arvalid = 0, s_arready, s_rvalid, s_rready = 0;
  logic [31:0] s_wdata = '0, s_rdata, rd;
  logic [3:0] s_wstrb = '0;
  logic [1:0] s_bresp, s_rresp, r;
  int err_total = 0, checks_done = 0, cyc = 0, n, ext;
  always #12.5 mclk = ~mclk;
  smc_ctrl #(.NUM_PER(8), .OSC_START(OSC)) dut_u (.mclk(mclk),
    .reset_n(reset_n), .clk_en(1'b1), .sleep_instr(sleep_instr),
    .wake_req(wake_req), .gate_on(gate_on), .cpu_halt(cpu_halt),
    .resume_pulse(resume_pulse), .per_clk_on(per_clk_on), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));
  smc_cpu_model cpu_u (.mclk(mclk), .reset_n(reset_n),
    .cmd_sleep(cmd_sleep), .cmd_wake(cmd_wake),
    .resume_pulse(resume_pulse), .gate_on(gate_on),
    .sleep_instr(sleep_instr), .wake_req(wake_req));
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] rs);
    logic aw, w, b;
    int k;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    b = 1'b0;
    k = 0;
    while (!b && k < 100) begin
      @(negedge mclk);
      aw = s_awvalid & s_awready;
      w = s_wvalid & s_wready;
      b = s_bvalid;
      rs = s_bresp;
      k++;
      @(posedge mclk);
      if (aw) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    // Let an edge pass so a following call never reassigns bready
    @(posedge mclk);
    if (!b) err_total++;
  endtask
  // AXI read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] rs);
    logic ar, b;
    int k;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    b = 1'b0;
    k = 0;
    while (!b && k < 100) begin
      @(negedge mclk);
      ar = s_arvalid & s_arready;
      b = s_rvalid;
      d = s_rdata;
      rs = s_rresp;
      k++;
      @(posedge mclk);
      if (ar) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
    // Let an edge pass so a following call never reassigns rready
    @(posedge mclk);
    if (!b) err_total++;
  endtask
  // One sleep instruction from the CPU model
  task automatic pulse_sleep();
    cmd_sleep <= 1'b1;
    @(posedge mclk);
    cmd_sleep <= 1'b0;
  endtask
  // Count cycles until the resume pulse
  task automatic wait_res(output int c);
    c = 0;
    do begin
      @(posedge mclk);
      cmd_wake <= '0;
      #1;
      c++;
    end while (!resume_pulse && c < 300);
  endtask
  // Raise a wake source and check the latency
  task automatic wake_lat(input smc_wake_type w, input int exp);
    int c;
    cmd_wake <= w;
    wait_res(c);
    chk(32'(c), 32'(exp));
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(32'(gate_on), 32'h1f);
    chk(32'(per_clk_on), 32'hff);
    chk(32'(cpu_halt), 32'h0);
    // Every mode against an in-range wake source, all but idle also against an out-of-range one
    for (int i = 0; i < 9; i++) begin
      axi_wr(SMC_ADDR_CTRL, {28'h0, rows[i].mode, 1'b1}, r);
      pulse_sleep();
      repeat (4) @(posedge mclk);
      #1;
      chk(32'(gate_on), 32'(rows[i].g));
      chk(32'(cpu_halt), 32'h1);
      ext = (rows[i].mode == SMC_MODE_FULL || rows[i].mode == SMC_MODE_CNT)
            ? OSC : 0;
      if (rows[i].hit) begin
        wake_lat(rows[i].w, LAT + ext);
      end else begin
        cmd_wake <= rows[i].w;
        repeat (10) @(posedge mclk);
        cmd_wake <= '0;
        #1;
        chk(32'(cpu_halt), 32'h1);
        wake_lat(4'h8, LAT + ext);
      end
      chk(32'(gate_on), 32'h1f);
      $display("mode row %0d done", i);
    end
    // Reserved codes and cleared enable are ignored
    axi_wr(SMC_ADDR_STATUS, 32'h3, r);
    for (int i = 0; i < 4; i++) begin
      axi_wr(SMC_ADDR_CTRL, refused[i], r);
      pulse_sleep();
      repeat (4) @(posedge mclk);
      #1;
      chk(32'(cpu_halt), 32'h0);
      axi_rd(SMC_ADDR_STATUS, rd, r);
      chk(rd, 32'h2);
      axi_wr(SMC_ADDR_STATUS, 32'h2, r);
    end
    $display("refused sleep done");
    // Interrupt, masking and kept registers
    axi_wr(SMC_ADDR_MASK, 32'h1, r);
    axi_wr(SMC_ADDR_CTRL, {28'h0, SMC_MODE_IDLE, 1'b1}, r);
    pulse_sleep();
    repeat (4) @(posedge mclk);
    wake_lat(4'h8, LAT);
    @(posedge mclk);
    #1;
    chk(32'(irq), 32'h1);
    axi_rd(SMC_ADDR_MASK, rd, r);
    chk(rd, 32'h1);
    axi_wr(SMC_ADDR_STATUS, 32'h1, r);
    @(posedge mclk);
    #1;
    chk(32'(irq), 32'h0);
    axi_wr(SMC_ADDR_MASK, 32'h0, r);
    $display("interrupt done");
    // Wake already pending at the instruction
    cmd_wake <= 4'h4;
    @(posedge mclk);
    cmd_wake <= '0;
    pulse_sleep();
    wait_res(n);
    chk(32'(n), 32'(LAT));
    $display("pending wake done");
    // Peripheral clock gating and unmapped addresses
    axi_wr(SMC_ADDR_GATE, 32'ha5, r);
    chk(32'(per_clk_on), 32'h5a);
    axi_rd(SMC_ADDR_GATE, rd, r);
    chk(rd, 32'ha5);
    axi_wr(SMC_ADDR_GATE, 32'h0, r);
    chk(32'(per_clk_on), 32'hff);
    axi_wr(8'h20, 32'h1, r);
    chk(32'(r), 32'(SMC_RESP_SLVERR));
    axi_rd(8'h24, rd, r);
    chk(32'(r), 32'(SMC_RESP_SLVERR));
    $display("gating done");
    // Reset taken in full-stop sleep
    axi_wr(SMC_ADDR_CTRL, {28'h0, SMC_MODE_FULL, 1'b1}, r);
    pulse_sleep();
    repeat (4) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(32'(gate_on), 32'h1f);
    chk(32'(cpu_halt), 32'h0);
    axi_rd(SMC_ADDR_STATE, rd, r);
    chk(rd, 32'h0);
    $display("reset in sleep done");
    finish_test();
  end
endmodule // sleep_mode_controller_tb
